// ===== logic/hslr_pkg.sv
package hslr_pkg;

    // reset values of the registered outputs and of the synchroniser and edge detector flops
    localparam logic RST_BUS_DRV_DIS_N = 1'b1;
    localparam logic RST_IRQ_OUT       = 1'b0;
    localparam logic RST_RELAY         = 1'b0;
    localparam logic RST_KEY_BUSY_N    = 1'b1;
    localparam logic RST_TX_EN         = 1'b0;
    localparam logic RST_SLEEP         = 1'b0;
    localparam logic RST_SYNC          = 1'b1;

    // synchroniser depth for pin inputs
    localparam int   SYNC_STAGES       = 2;

    typedef struct packed {
        logic select_n;
        logic read_strobe_n;
    } hslr_host_pins_t;

    typedef struct packed {
        logic hook_relay_drive;
        logic handset_relay_drive;
        logic key_line_busy_n;
    } hslr_relay_out_t;

    typedef enum logic [0:0] {
        HSLR_AWAKE,
        HSLR_ASLEEP
    } hslr_pwr_t;

endpackage

// ===== logic/hslr_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module hslr_ctrl (
    input  wire logic                      core_clk,
    input  wire logic                      nrst,
    input  wire logic                      clk_en,
    input  wire hslr_pkg::hslr_host_pins_t host_pins,
    input  wire logic                      irq_pending,
    input  wire logic                      irq_output_gate_bit,
    input  wire logic                      tx_enable,
    input  wire logic                      analog_loopback,
    input  wire logic                      off_hook_req,
    input  wire logic                      line_in_use,
    input  wire logic                      sleep_req,
    input  wire logic                      ring_detect_n,
    output logic                           bus_driver_disable_n,
    output logic                           host_irq_out,
    output logic                           line_tx_pos,
    output logic                           line_tx_neg,
    output hslr_pkg::hslr_relay_out_t      relay_out,
    output logic                           asleep,
    output logic                           ring_wake
);


    // pin order in the synchroniser bank
    localparam int PIN_SEL  = 0;
    localparam int PIN_RD   = 1;
    localparam int PIN_RING = 2;
    localparam int NUM_PINS = 3;

    // synchroniser bank
    logic [NUM_PINS-1:0]              pin_raw;
    logic [hslr_pkg::SYNC_STAGES-1:0] pin_sync_q [NUM_PINS];
    logic [NUM_PINS-1:0]              pin_sync;
    logic                             ring_prev_q;
    logic                             ring_fall;

    // power state
    hslr_pkg::hslr_pwr_t              pwr_q;
    hslr_pkg::hslr_pwr_t              pwr_d;
    logic                             asleep_q;
    logic                             is_asleep;
    logic                             next_awake;
    logic                             enter_sleep;
    logic                             leave_sleep;

    // host side
    logic                             read_active;
    logic                             drv_dis_n_q;
    logic                             drv_dis_n_d;
    logic                             irq_q;
    logic                             irq_d;

    // line side
    logic                             tx_on_d;
    logic                             tx_pos_q;
    logic                             tx_neg_q;
    logic                             hook_d;
    logic                             hook_q;
    logic                             handset_q;
    logic                             busy_n_d;
    logic                             busy_n_q;

    // power state decode, shared by the relay gate and the status outputs
    function automatic logic pwr_is_asleep(input hslr_pkg::hslr_pwr_t p);
        return (p == hslr_pkg::HSLR_ASLEEP);
    endfunction

    // host strobes and ring detect all arrive from outside this clock
    assign pin_raw[PIN_SEL]  = host_pins.select_n;
    assign pin_raw[PIN_RD]   = host_pins.read_strobe_n;
    assign pin_raw[PIN_RING] = ring_detect_n;

    // every pin passes two flops and only the last one is read, so a
    // metastable first stage never reaches the decode
    for (genvar g = 0; g < NUM_PINS; g++)
    begin : g_sync
        always_ff @(posedge core_clk or negedge nrst)
        begin
            if (!nrst)
            begin
                pin_sync_q[g] <= {hslr_pkg::SYNC_STAGES{hslr_pkg::RST_SYNC}};
            end
            else if (clk_en)
            begin
                pin_sync_q[g] <= {pin_sync_q[g][hslr_pkg::SYNC_STAGES-2:0], pin_raw[g]};
            end
        end

        assign pin_sync[g] = pin_sync_q[g][hslr_pkg::SYNC_STAGES-1];
    end

    // edge detector starts at the idle high level so reset gives no false edge
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ring_prev_q <= hslr_pkg::RST_SYNC;
        end
        else if (clk_en)
        begin
            ring_prev_q <= pin_sync[PIN_RING];
        end
    end

    // a fall is a high sample followed by a low one, held until the next clk_en edge
    assign ring_fall = ring_prev_q & ~pin_sync[PIN_RING];

    // a ring edge wins over a sleep request so an incoming call is not lost
    assign enter_sleep = sleep_req & ~ring_fall;
    assign leave_sleep = ring_fall;
    assign is_asleep   = pwr_is_asleep(pwr_q);
    assign next_awake  = ~pwr_is_asleep(pwr_d);

    // sleep is left only by a ring edge
    always_comb
    begin
        pwr_d = pwr_q;
        unique case (pwr_q)
            hslr_pkg::HSLR_AWAKE:
            begin
                if (enter_sleep)
                begin
                    pwr_d = hslr_pkg::HSLR_ASLEEP;
                end
                else
                begin
                    pwr_d = hslr_pkg::HSLR_AWAKE;
                end
            end
            hslr_pkg::HSLR_ASLEEP:
            begin
                if (leave_sleep)
                begin
                    pwr_d = hslr_pkg::HSLR_AWAKE;
                end
                else
                begin
                    pwr_d = hslr_pkg::HSLR_ASLEEP;
                end
            end
        endcase
    end

    // power state starts awake
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pwr_q <= hslr_pkg::HSLR_AWAKE;
        end
        else if (clk_en)
        begin
            pwr_q <= pwr_d;
        end
    end

    // asleep has its own flop with the same next value as the state,
    // so the status output is a plain flop output
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            asleep_q <= hslr_pkg::RST_SLEEP;
        end
        else if (clk_en)
        begin
            asleep_q <= ~next_awake;
        end
    end

    // host side: the strobes lag by the sync depth, so the disable follows
    // a read three cycles late; fine for a slow parallel bus
    assign read_active = ~pin_sync[PIN_SEL] & ~pin_sync[PIN_RD];
    assign drv_dis_n_d = ~read_active;
    assign irq_d       = irq_pending & irq_output_gate_bit;

    // transceivers stay enabled out of reset
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            drv_dis_n_q <= hslr_pkg::RST_BUS_DRV_DIS_N;
        end
        else if (clk_en)
        begin
            drv_dis_n_q <= drv_dis_n_d;
        end
    end

    // interrupt line is registered so gate changes give no glitch
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_q <= hslr_pkg::RST_IRQ_OUT;
        end
        else if (clk_en)
        begin
            irq_q <= irq_d;
        end
    end

    // line side
    assign tx_on_d  = tx_enable & ~analog_loopback;
    // relays drop on the edge that enters sleep, not one cycle later
    assign hook_d   = off_hook_req & next_awake;
    assign busy_n_d = ~line_in_use;

    // each leg has its own flop but one shared next value
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tx_pos_q <= hslr_pkg::RST_TX_EN;
        end
        else if (clk_en)
        begin
            tx_pos_q <= tx_on_d;
        end
    end

    // negative leg, same enable and next value as the positive one
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tx_neg_q <= hslr_pkg::RST_TX_EN;
        end
        else if (clk_en)
        begin
            tx_neg_q <= tx_on_d;
        end
    end

    // hook and handset flops share one next value and one enable,
    // so both relays always change on the same edge
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            hook_q <= hslr_pkg::RST_RELAY;
        end
        else if (clk_en)
        begin
            hook_q <= hook_d;
        end
    end

    // handset relay follows the hook relay's next value
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            handset_q <= hslr_pkg::RST_RELAY;
        end
        else if (clk_en)
        begin
            handset_q <= hook_d;
        end
    end

    // key line indicator idles high
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            busy_n_q <= hslr_pkg::RST_KEY_BUSY_N;
        end
        else if (clk_en)
        begin
            busy_n_q <= busy_n_d;
        end
    end

    assign bus_driver_disable_n          = drv_dis_n_q;
    assign host_irq_out                  = irq_q;
    assign line_tx_pos                   = tx_pos_q;
    assign line_tx_neg                   = tx_neg_q;
    assign relay_out.hook_relay_drive    = hook_q;
    assign relay_out.handset_relay_drive = handset_q;
    assign relay_out.key_line_busy_n     = busy_n_q;
    // status outputs
    assign asleep                        = asleep_q;
    assign ring_wake                     = ring_fall & is_asleep;

endmodule
`default_nettype wire

// ===== tb/hslr_chk.sv
`timescale 1ns/1ns
`default_nettype none
module hslr_chk (
    input wire logic                      core_clk,
    input wire logic                      nrst,
    input wire logic                      clk_en,
    input wire logic                      irq_pending,
    input wire logic                      irq_output_gate_bit,
    input wire logic                      tx_enable,
    input wire logic                      analog_loopback,
    input wire logic                      off_hook_req,
    input wire logic                      line_in_use,
    input wire logic                      bus_driver_disable_n,
    input wire logic                      host_irq_out,
    input wire logic                      line_tx_pos,
    input wire logic                      line_tx_neg,
    input wire logic                      asleep,
    input wire logic                      ring_wake,
    input wire hslr_pkg::hslr_host_pins_t host_pins,
    input wire hslr_pkg::hslr_relay_out_t relay_out
);
    // high when the previous edge was out of reset and enabled, so the flops moved
    logic moved_q = 1'b0;
    always_ff @(posedge core_clk)
        moved_q <= nrst && clk_en;
    // strobes pass two sync flops, so five low samples leave margin for the output flop
    wire rd = !host_pins.select_n && !host_pins.read_strobe_n;
    wire hk = relay_out.hook_relay_drive;
    wire hs = relay_out.handset_relay_drive;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    AST_RD_LOW: assert property ((rd && clk_en)[*5] |-> !bus_driver_disable_n)
        else $error("disable high in read");
    AST_RD_HIGH: assert property ((!rd && clk_en)[*5] |-> bus_driver_disable_n)
        else $error("disable low idle");
    AST_IRQ: assert property (moved_q |->
        host_irq_out == $past(irq_pending && irq_output_gate_bit)) else $error("irq wrong");
    AST_TX: assert property (moved_q |->
        line_tx_pos == $past(tx_enable && !analog_loopback) && line_tx_neg == line_tx_pos)
        else $error("tx wrong");
    AST_SLEEP_OFF: assert property (asleep |-> !hk && !hs) else $error("relay on asleep");
    AST_PAIR: assert property (hk == hs) else $error("relays differ");
    AST_HOOK: assert property (moved_q && !asleep |-> hk == $past(off_hook_req))
        else $error("hook wrong");
    AST_WAKE: assert property (ring_wake && clk_en |-> asleep ##1 !asleep) else $error("no wake");
    AST_BUSY: assert property (moved_q |-> relay_out.key_line_busy_n == !$past(line_in_use))
        else $error("busy wrong");
    AST_ONE: assert property (ring_wake && clk_en |=> !ring_wake) else $error("wake too long");
    cover property (rd[*5]);
    cover property (ring_wake);
    cover property ($rose(asleep));
endmodule
bind hslr_ctrl hslr_chk i_chk (.*);
`default_nettype wire

// ===== tb/hslr_host.sv
`timescale 1ns/1ns
`default_nettype none
module hslr_host (
    input wire logic               core_clk,
    output hslr_pkg::hslr_host_pins_t host_pins
);
    initial host_pins = 2'h3;
    // pins change only after a falling edge and hold until the next call
    task automatic drive(input logic [1:0] p);
        @(negedge core_clk);
        host_pins = p;
    endtask
endmodule
`default_nettype wire

// ===== tb/hslr_ctrl_test.sv
`timescale 1ns/1ns
`default_nettype none
module hslr_ctrl_test;
    logic core_clk = 1'b0, nrst = 1'b0, irq_pending = 1'b0, irq_output_gate_bit = 1'b0;
    logic tx_enable = 1'b0, analog_loopback = 1'b0, off_hook_req = 1'b0, line_in_use = 1'b0;
    logic sleep_req = 1'b0, ring_detect_n = 1'b1, dis_n, irq, txp, txn, asleep, ring_wake;
    logic clk_en = 1'b1;
    hslr_pkg::hslr_host_pins_t pins;
    hslr_pkg::hslr_relay_out_t ro;
    int mismatches = 0, n_tests = 0, w;
    hslr_host i_host (.core_clk(core_clk), .host_pins(pins));
    hslr_ctrl i_dut (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .host_pins(pins),
        .irq_pending(irq_pending), .irq_output_gate_bit(irq_output_gate_bit),
        .tx_enable(tx_enable), .analog_loopback(analog_loopback), .off_hook_req(off_hook_req),
        .line_in_use(line_in_use), .sleep_req(sleep_req), .ring_detect_n(ring_detect_n),
        .bus_driver_disable_n(dis_n), .host_irq_out(irq), .line_tx_pos(txp),
        .line_tx_neg(txn), .relay_out(ro), .asleep(asleep), .ring_wake(ring_wake));
    initial forever #5 core_clk = ~core_clk;
    task automatic chk(input logic a, input logic e);
        n_tests++;
        if (a !== e)
        begin
            mismatches++;
            $display("[ERR] %0t mismatch", $time);
        end
    endtask
    task automatic close_out;
        $display("tests %0d errors %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        #5000;
        mismatches++;
        close_out;
    end
    initial
    begin
        repeat (8) @(negedge core_clk);
        nrst = 1'b1;
        // only both pins low counts as a read; lone select or strobe must not open the bus
        for (int i = 0; i < 4; i++)
        begin
            i_host.drive(i[1:0]);
            repeat (5) @(negedge core_clk);
            chk(dis_n, i != 0);
        end
        $display("read test done");
        for (int i = 0; i < 4; i++)
        begin
            {irq_output_gate_bit, irq_pending} = i[1:0];
            {analog_loopback, tx_enable} = i[1:0];
            {off_hook_req, line_in_use} = i[1:0];
            repeat (2) @(negedge core_clk);
            chk(irq, i == 3);
            chk(txp, i == 1);
            chk(txn, i == 1);
            chk(ro.key_line_busy_n, !i[0]);
            chk(ro.hook_relay_drive & ro.handset_relay_drive, i[1]);
        end
        $display("level test done");
        // a low enable must freeze the outputs, then they follow again
        clk_en = 1'b0;
        line_in_use = 1'b0;
        repeat (2) @(negedge core_clk);
        chk(ro.key_line_busy_n, 1'b0);
        clk_en = 1'b1;
        repeat (2) @(negedge core_clk);
        chk(ro.key_line_busy_n, 1'b1);
        $display("freeze test done");
        sleep_req = 1'b1;
        repeat (2) @(negedge core_clk);
        chk(asleep, 1'b1);
        chk(ro.hook_relay_drive | ro.handset_relay_drive, 1'b0);
        sleep_req = 1'b0;
        ring_detect_n = 1'b0;
        w = 0;
        repeat (8)
        begin
            @(negedge core_clk);
            w += ring_wake;
        end
        chk(w == 1, 1'b1);
        chk(asleep | !ro.hook_relay_drive, 1'b0);
        $display("sleep test done");
        close_out;
    end
endmodule
`default_nettype wire
